// ==== logic/dsf_link.sv ====
// serial-clock side of the write port: 24-bit shifter, frame counter, readback shifter
// assumes the host drives serial_clk only inside frames; words leave by a toggle handshake
`timescale 1ns/1ps
module dsf_link
   import dsf_pkg::*;
(
   // link clock and resets
   input wire logic serial_clk_in,
   input wire logic rst_b_in,
   // serial pins
   input wire logic frame_n_in,
   input wire logic serial_in,
   output logic serial_out,
   // word to the system domain
   output logic [WORD_BITS-1:0] word_out,
   output logic word_tgl_out
);

   logic [WORD_BITS-1:0] shift_r;
   logic [CNT_BITS-1:0] count_r;
   logic done_r;
   logic [WORD_BITS-1:0] word_r;
   logic tgl_r;
   logic sdo_r;
   wire active = ~frame_n_in & ~done_r;
   wire [WORD_BITS-1:0] shift_nxt = {shift_r[WORD_BITS-2:0], serial_in};
   wire last_edge = active & (count_r == LAST_BIT);

   // counter restarts whenever the frame select is high, even with the clock stopped
   always_ff @(negedge serial_clk_in or posedge frame_n_in or negedge rst_b_in) begin
      if (!rst_b_in || frame_n_in) begin
         count_r <= '0;
         done_r <= 1'b0;
      end else if (active) begin
         count_r <= count_r + 5'h01;
         done_r <= (count_r == LAST_BIT);
      end
   end

   always_ff @(negedge serial_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         shift_r <= WORD_RESET;
      end else if (active) begin
         shift_r <= shift_nxt;
      end
   end

   // the word is held for a whole frame, far longer than the receiving synchroniser needs
   always_ff @(negedge serial_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         word_r <= WORD_RESET;
         tgl_r <= 1'b0;
      end else if (last_edge) begin
         word_r <= shift_nxt;
         tgl_r <= ~tgl_r;
      end
   end

   // readback bit changes on the rising edge so the far end can take it on the falling one
   always_ff @(posedge serial_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sdo_r <= 1'b0;
      end else begin
         sdo_r <= shift_r[WORD_BITS-1];
      end
   end

   assign serial_out = sdo_r;
   assign word_out = word_r;
   assign word_tgl_out = tgl_r;

endmodule : dsf_link

// ==== logic/dsf_top.sv ====
// digital front end of a dual converter: serial write port, reset pin, level select, load pin
// assumes all control pins are asynchronous to sys_clk_in and the serial clock comes from the host
`timescale 1ns/1ps
module dsf_top
   import dsf_pkg::*;
(
   // system clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   // serial write port, clocked by the host
   input wire logic serial_clk_in,
   input wire logic frame_n_in,
   input wire logic serial_in,
   output logic serial_out,
   // control pins
   input wire logic reset_n_in,
   input wire logic load_outputs_n_in,
   input wire logic reset_level_select_in,
   // converter side
   output logic [dsf_pkg::CODE_BITS-1:0] code_a_out,
   output logic [dsf_pkg::CODE_BITS-1:0] code_b_out,
   output logic ref_out_en_out,
   output logic ready_out
);
   import dsf_pkg::*;

   // link side
   logic [WORD_BITS-1:0] link_word;
   logic link_tgl;

   dsf_link u_link (
      .serial_clk_in(serial_clk_in),
      .rst_b_in(rst_b_in),
      .frame_n_in(frame_n_in),
      .serial_in(serial_in),
      .serial_out(serial_out),
      .word_out(link_word),
      .word_tgl_out(link_tgl)
   );

   // pin synchronisers: meta stage feeds only the sync stage
   logic [NUM_PINS-1:0] pin_meta_r;
   logic [NUM_PINS-1:0] pin_sync_r;
   logic [NUM_PINS-1:0] pin_prev_r;
   wire [NUM_PINS-1:0] pin_raw = {reset_level_select_in, load_outputs_n_in, reset_n_in};

   generate
      for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
         // the reset pin counts as low until it is really seen high, so initialisation
         // cannot start from the flops' own reset value while the pin is held down
         localparam logic PIN_IDLE = (p == PIN_RESET) ? 1'b0 : 1'b1;
         always_ff @(posedge sys_clk_in) begin
            if (!rst_b_in) begin
               pin_meta_r[p] <= PIN_IDLE;
               pin_sync_r[p] <= PIN_IDLE;
               pin_prev_r[p] <= PIN_IDLE;
            end else begin
               pin_meta_r[p] <= pin_raw[p];
               pin_sync_r[p] <= pin_meta_r[p];
               pin_prev_r[p] <= pin_sync_r[p];
            end
         end
      end
   endgenerate

   wire reset_pin_high = pin_sync_r[PIN_RESET];
   wire reset_fall = pin_prev_r[PIN_RESET] & ~pin_sync_r[PIN_RESET];
   wire load_fall = pin_prev_r[PIN_LOAD] & ~pin_sync_r[PIN_LOAD];
   wire load_low = ~pin_sync_r[PIN_LOAD];
   wire level_high = pin_sync_r[PIN_LEVEL];

   // a reset pulse shorter than one system clock may be missed; this is the price of
   // keeping the channel registers on the system clock instead of an asynchronous clear
   wire [CODE_BITS-1:0] reset_code = level_high ? MID_CODE : ZERO_CODE;

   // word handshake from the link domain
   logic tgl_meta_r;
   logic tgl_sync_r;
   logic tgl_prev_r;
   logic [WORD_BITS-1:0] word_r;
   logic word_vld_r;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         tgl_meta_r <= 1'b0;
         tgl_sync_r <= 1'b0;
         tgl_prev_r <= 1'b0;
      end else begin
         tgl_meta_r <= link_tgl;
         tgl_sync_r <= tgl_meta_r;
         tgl_prev_r <= tgl_sync_r;
      end
   end

   wire word_arrive = tgl_sync_r ^ tgl_prev_r;

   // the link word is stable for a full frame after its toggle, so it is safe to sample here
   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         word_r <= WORD_RESET;
         word_vld_r <= 1'b0;
      end else begin
         word_vld_r <= word_arrive;
         if (word_arrive) begin
            word_r <= link_word;
         end
      end
   end

   // power-on sequencing
   logic por_done_r;
   wire por_fire = ~por_done_r & reset_pin_high;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         por_done_r <= 1'b0;
      end else if (por_fire) begin
         por_done_r <= 1'b1;
      end
   end

   // frame decode, only once initialisation is complete
   wire [3:0] cmd_bits = word_r[CMD_MSB:CMD_LSB];
   wire [3:0] addr_bits = word_r[ADDR_MSB:ADDR_LSB];
   wire [CODE_BITS-1:0] frame_code = word_r[CODE_MSB:CODE_LSB];
   wire take = word_vld_r & por_done_r;
   wire cmd_write = take & ((cmd_bits == DSF_CMD_WRITE) | (cmd_bits == DSF_CMD_WRITE_UPDATE));
   wire cmd_update = take & ((cmd_bits == DSF_CMD_UPDATE) | (cmd_bits == DSF_CMD_WRITE_UPDATE));
   wire cmd_ref = take & (cmd_bits == DSF_CMD_REF_SETUP);

   // load pin only counts while the reset pin is high
   wire load_pulse = load_fall & reset_pin_high & por_done_r;
   wire load_held = load_low & reset_pin_high;
   wire hard_reset = por_done_r & reset_fall;

   // internal reference on the shared pin
   logic ref_en_r;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         ref_en_r <= 1'b1;
      end else if (cmd_ref) begin
         ref_en_r <= ~word_r[REF_OFF_BIT];
      end
   end

   // per-channel input and output registers
   logic [CODE_BITS-1:0] in_r [NUM_CH];
   logic [CODE_BITS-1:0] out_r [NUM_CH];
   logic [NUM_CH-1:0] new_r;

   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
         wire hit = addr_bits[c];
         wire wr = cmd_write & hit;
         wire upd = cmd_update & hit;
         // a write straight to the output when the load pin is tied low
         wire wr_through = wr & (upd | load_held);
         wire copy = (upd & ~wr) | (load_pulse & new_r[c]);
         wire [CODE_BITS-1:0] in_nxt = wr ? frame_code : in_r[c];
         wire [CODE_BITS-1:0] out_nxt = wr_through ? frame_code :
                                        (copy ? in_r[c] : out_r[c]);
         wire new_nxt = wr ? ~wr_through : (copy ? 1'b0 : new_r[c]);

         always_ff @(posedge sys_clk_in) begin
            if (!rst_b_in) begin
               in_r[c] <= ZERO_CODE;
               out_r[c] <= ZERO_CODE;
               new_r[c] <= 1'b0;
            end else if (por_fire || hard_reset) begin
               in_r[c] <= reset_code;
               out_r[c] <= reset_code;
               new_r[c] <= 1'b0;
            end else begin
               in_r[c] <= in_nxt;
               out_r[c] <= out_nxt;
               new_r[c] <= new_nxt;
            end
         end
      end
   endgenerate

   assign code_a_out = out_r[0];
   assign code_b_out = out_r[1];
   assign ref_out_en_out = ref_en_r;
   assign ready_out = por_done_r;

endmodule : dsf_top

// ==== shared/dsf_pkg.sv ====
// constants shared by the serial front end and its link-side shifter
// assumes a 125 MHz system clock and a host-driven serial clock of at most 50 MHz
package dsf_pkg;

   // serial frame shape
   localparam int WORD_BITS = 24;
   localparam int CNT_BITS = 5;
   localparam logic [4:0] LAST_BIT = 5'h17;
   localparam int SCLK_MAX_MHZ = 50;

   // frame fields, msb first on the wire
   localparam int CMD_MSB = 23;
   localparam int CMD_LSB = 20;
   localparam int ADDR_MSB = 19;
   localparam int ADDR_LSB = 16;
   localparam int CODE_MSB = 15;
   localparam int CODE_LSB = 6;
   localparam int REF_OFF_BIT = 0;

   // converter codes
   localparam int CODE_BITS = 10;
   localparam int NUM_CH = 2;
   localparam logic [9:0] ZERO_CODE = 10'h000;
   localparam logic [9:0] MID_CODE = 10'h200;
   localparam logic [23:0] WORD_RESET = 24'h00_0000;

   // pin vector positions in the synchronised group
   localparam int PIN_RESET = 0;
   localparam int PIN_LOAD = 1;
   localparam int PIN_LEVEL = 2;
   localparam int NUM_PINS = 3;

   typedef enum logic [3:0] {
      DSF_CMD_NOP = 4'h0,
      DSF_CMD_WRITE = 4'h1,
      DSF_CMD_UPDATE = 4'h2,
      DSF_CMD_WRITE_UPDATE = 4'h3,
      DSF_CMD_REF_SETUP = 4'h7
   } dsf_cmd_type;

endpackage : dsf_pkg

// ==== tb/dsf_host_model.sv ====
// host side of the serial write port: frames words and captures readback
// assumes the caller leaves a gap of several serial periods between frames
`timescale 1ns/1ps
module dsf_host_model (
   // serial pins toward the device
   output logic serial_clk_out,
   output logic frame_n_out,
   output logic serial_data_out,
   // readback
   input wire logic serial_out_in,
   output logic [23:0] rx_word_out
);
   initial begin
      serial_clk_out = 1'b1;
      frame_n_out = 1'b1;
      serial_data_out = 1'b0;
      rx_word_out = 24'h00_0000;
   end
   // clock stands high between frames; 20 ns period inside, the fastest the port takes
   // nbits below 24 cuts the frame short, which the device must discard
   task automatic send(input logic [23:0] word, input int nbits = 24);
      #3 frame_n_out = 1'b0;
      for (int i = 23; i >= 24 - nbits; i--) begin
         serial_data_out = word[i];
         #10 serial_clk_out = 1'b0;
         rx_word_out = {rx_word_out[22:0], serial_out_in};
         #10 serial_clk_out = 1'b1;
      end
      frame_n_out = 1'b1;
      serial_data_out = ~serial_data_out; // released line shows no stale bit
   endtask : send
endmodule : dsf_host_model

// ==== tb/dsf_top_checker.sv ====
// port assertions for the converter front end
// assumes the pins stay steady around events; bound into every dsf_top
`timescale 1ns/1ps
module dsf_top_checker
   import dsf_pkg::*;
(
   // clock, reset and pins watched
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic frame_n_in,
   input wire logic reset_n_in,
   input wire logic load_outputs_n_in,
   input wire logic reset_level_select_in,
   input wire logic [dsf_pkg::CODE_BITS-1:0] code_a_out,
   input wire logic [dsf_pkg::CODE_BITS-1:0] code_b_out,
   input wire logic ref_out_en_out,
   input wire logic ready_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   wire logic [CODE_BITS-1:0] lvl = reset_level_select_in ? MID_CODE : ZERO_CODE;
   sequence s_quiet;
      (!frame_n_in && load_outputs_n_in && reset_n_in) [*8];
   endsequence
   sequence s_pin_fall;
      ready_out && $fell(reset_n_in) && $stable(reset_level_select_in);
   endsequence
   property p_init;
      disable iff (1'b0) !rst_b_in |=> !ready_out && ref_out_en_out;
   endproperty
   property p_blank;
      !ready_out |-> code_a_out == ZERO_CODE && code_b_out == ZERO_CODE;
   endproperty
   property p_wait_pin;
      !ready_out && !reset_n_in |=> !ready_out;
   endproperty
   property p_ready_by;
      reset_n_in [*8] |-> ready_out;
   endproperty
   property p_pwr_level;
      $rose(ready_out) |-> code_a_out == lvl && code_b_out == lvl;
   endproperty
   property p_ref_dflt;
      $rose(ready_out) |-> ref_out_en_out;
   endproperty
   property p_rst_level;
      s_pin_fall |-> ##[1:5] (code_a_out == lvl && code_b_out == lvl);
   endproperty
   property p_load_ign;
      (!reset_n_in && frame_n_in) [*8] |=> $stable(code_a_out) && $stable(code_b_out);
   endproperty
   property p_frame_q;
      s_quiet |-> $stable(code_a_out) && $stable(code_b_out);
   endproperty
   a_init: assert property (p_init) else $error("bad reset values");
   a_blank: assert property (p_blank) else $error("codes before ready");
   a_wait_pin: assert property (p_wait_pin) else $error("ready with pin low");
   a_ready_by: assert property (p_ready_by) else $error("ready late");
   a_pwr_level: assert property (p_pwr_level) else $error("power-up level");
   a_ref_dflt: assert property (p_ref_dflt) else $error("reference off");
   a_rst_level: assert property (p_rst_level) else $error("reset level");
   a_load_ign: assert property (p_load_ign) else $error("load in reset");
   a_frame_q: assert property (p_frame_q) else $error("code moved in frame");
endmodule : dsf_top_checker
bind dsf_top dsf_top_checker u_chk (.sys_clk_in, .rst_b_in, .frame_n_in, .reset_n_in,
   .load_outputs_n_in, .reset_level_select_in, .code_a_out, .code_b_out,
   .ref_out_en_out, .ready_out);

// ==== tb/tb_top.sv ====
// self-checking bench for the converter front end
// assumes the host model owns the serial pins; control pins move on sys_clk_in edges
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import dsf_pkg::*;
   typedef struct packed {logic [23:0] w; logic [9:0] a; logic [9:0] b; logic r;} dsf_row_type;
   logic sys_clk, rst_b, reset_n, load_n, level, ref_en, ready;
   wire logic sclk, frame_n, sdata, sout;
   logic [9:0] code_a, code_b;
   logic [23:0] rx;
   int mismatches = 0;
   int samples_checked = 0;
   dsf_row_type rows [7] = '{'{24'h33_FFC0, 10'h3FF, 10'h3FF, 1'b1},
      '{24'h31_0000, 10'h000, 10'h3FF, 1'b1}, '{24'h12_2A80, 10'h000, 10'h3FF, 1'b1},
      '{24'h22_0000, 10'h000, 10'h0AA, 1'b1}, '{24'h03_FFC0, 10'h000, 10'h0AA, 1'b1},
      '{24'h70_0001, 10'h000, 10'h0AA, 1'b0}, '{24'h70_0000, 10'h000, 10'h0AA, 1'b1}};
   dsf_top dut (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .serial_clk_in(sclk),
      .frame_n_in(frame_n), .serial_in(sdata), .serial_out(sout), .reset_n_in(reset_n),
      .load_outputs_n_in(load_n), .reset_level_select_in(level), .code_a_out(code_a),
      .code_b_out(code_b), .ref_out_en_out(ref_en), .ready_out(ready));
   dsf_host_model host (.serial_clk_out(sclk), .frame_n_out(frame_n),
      .serial_data_out(sdata), .serial_out_in(sout), .rx_word_out(rx));
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   task automatic pulse_load();
      load_n <= 1'b0;
      tick(3);
      load_n <= 1'b1;
      tick(8);
   endtask : pulse_load
   task automatic finish_test();
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // the run needs about 830 cycles
   initial begin
      tick(20000);
      mismatches++;
      finish_test();
   end
   initial begin
      rst_b = 1'b0;
      reset_n = 1'b0;
      load_n = 1'b1;
      level = 1'b1;
      tick(6);
      rst_b <= 1'b1;
      tick(12);
      `CHK("ready held", 1'b0, ready)
      reset_n <= 1'b1;
      for (int k = 0; k < 12 && ready !== 1'b1; k++) begin
         tick(1);
      end
      `CHK("ready up", 1'b1, ready)
      `CHK("power-up a", MID_CODE, code_a)
      `CHK("power-up b", MID_CODE, code_b)
      `CHK("ref default", 1'b1, ref_en)
      foreach (rows[i]) begin
         host.send(rows[i].w);
         tick(10);
         `CHK("code a", rows[i].a, code_a)
         `CHK("code b", rows[i].b, code_b)
         `CHK("ref en", rows[i].r, ref_en)
         if (i > 0) begin
            `CHK("readback", rows[i-1].w, rx)
         end
      end
      host.send(24'h33_0000, 12);
      tick(10);
      `CHK("cut frame a", 10'h000, code_a)
      `CHK("cut frame b", 10'h0AA, code_b)
      host.send(24'h11_5540);
      tick(10);
      `CHK("before load", 10'h000, code_a)
      pulse_load();
      `CHK("after load", 10'h155, code_a)
      `CHK("after load b", 10'h0AA, code_b)
      // load pin held low: a write goes straight through to the output
      load_n <= 1'b0;
      tick(4);
      host.send(24'h12_0000);
      tick(10);
      `CHK("load held b", 10'h000, code_b)
      load_n <= 1'b1;
      tick(4);
      level <= 1'b0;
      tick(4);
      reset_n <= 1'b0;
      tick(8);
      `CHK("reset a", ZERO_CODE, code_a)
      `CHK("reset b", ZERO_CODE, code_b)
      host.send(24'h13_FFC0);
      tick(10);
      pulse_load();
      `CHK("load in reset", ZERO_CODE, code_a)
      reset_n <= 1'b1;
      tick(10);
      `CHK("ready again", 1'b1, ready)
      // data written while the pin was low is still new and loads both channels now
      pulse_load();
      `CHK("late load a", 10'h3FF, code_a)
      `CHK("late load b", 10'h3FF, code_b)
      // second power-up, level select low this time
      rst_b <= 1'b0;
      tick(4);
      `CHK("ready cleared", 1'b0, ready)
      rst_b <= 1'b1;
      for (int k = 0; k < 12 && ready !== 1'b1; k++) begin
         tick(1);
      end
      `CHK("ready zero", 1'b1, ready)
      `CHK("zero scale a", ZERO_CODE, code_a)
      `CHK("zero scale b", ZERO_CODE, code_b)
      `CHK("ref after", 1'b1, ref_en)
      finish_test();
   end
endmodule : tb_top
